// >>> core/phy_ctrl.sv
// PHY control block: serializer, deserializer, OOB control and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module phy_ctrl
  import phy_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxSer,
  input wire logic rxLineClk,
  input wire logic comresetSense,
  input wire logic cominitSense,
  input wire logic comwakeSense,
  output logic txSer,
  output logic txOob,
  output logic linkUp,
  output logic seenA,
  output logic resetDet,
  output logic wakeDet,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages, filtered when stages two and three agree
  logic [4:0] pinIn;
  logic [4:0] syncQ [3];
  logic [4:0] fltQ;
  assign pinIn = {comwakeSense, cominitSense, comresetSense, rxLineClk, rxSer};
  // Shift stages
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncQ[0] <= 5'h0_0;
      syncQ[1] <= 5'h0_0;
      syncQ[2] <= 5'h0_0;
    end
    else
    begin
      syncQ[0] <= pinIn;
      syncQ[1] <= syncQ[0];
      syncQ[2] <= syncQ[1];
    end
  end
  // Per-bit filter
  genvar g;
  generate
    for (g = 0; g < 5; g++)
    begin : gFlt
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          fltQ[g] <= 1'b0;
        else if (syncQ[1][g] == syncQ[2][g])
          fltQ[g] <= syncQ[2][g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  ctrl_s ctrl_q, ctrl_d;
  logic [9:0] txWord_q, txWord_d;
  logic [9:0] rxWord_q, rxWord_d;
  logic [EV_W-1:0] stat_q, stat_d, en_q, en_d, ev;
  logic awready_q, awready_d, arready_q, arready_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  // Link state
  link_state_e st_q, st_d;
  logic [15:0] tmr_q, tmr_d;
  logic [3:0] div_q, div_d, txCnt_q, txCnt_d, rxCnt_q, rxCnt_d;
  logic [9:0] txSh_q, txSh_d, rxSh_q, rxSh_d;
  logic [1:0] alIdx_q, alIdx_d, alCnt_q, alCnt_d, rate_q, rate_d;
  logic txSer_q, txSer_d, txOob_q, txOob_d, linkUp_q, linkUp_d, seenA_q, seenA_d;
  logic resetDet_q, resetDet_d, wakeDet_q, wakeDet_d, lclk_q, rxValid_q, rxValid_d;
  logic bitEn, rxEn, rxBit, seen_a;
  logic [3:0] divTop;
  logic [9:0] nextSym;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, events and interrupt
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction
  logic wrGo, rdGo;
  logic [31:0] mrgCtrl, mrgTx, mrgEn;
  // Byte-lane merges, cut to register width at use
  assign mrgCtrl = merge({22'h0, ctrl_q}, wdata, wstrb);
  assign mrgTx = merge({22'h0, txWord_q}, wdata, wstrb);
  assign mrgEn = merge({27'h0, en_q}, wdata, wstrb);
  assign wrGo = awvalid && wvalid && awready_q && wready;
  assign rdGo = arvalid && arready_q;
  assign ev = {wakeDet_d & ~wakeDet_q, resetDet_d & ~resetDet_q, linkUp_d & ~linkUp_q, rxValid_d, seenA_d};
  // Decode, write and read next values
  always_comb
  begin
    ctrl_d = ctrl_q;
    txWord_d = txWord_q;
    en_d = en_q;
    awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
    arready_d = arvalid && !arready_q && !rvalid_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    stat_d = stat_q;
    if (wrGo)
    begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OK;
      unique case (awaddr)
        CTRL_OFS: ctrl_d = ctrl_s'(mrgCtrl[9:0]);
        TXWORD_OFS: txWord_d = mrgTx[9:0];
        IRQ_EN_OFS: en_d = mrgEn[EV_W-1:0];
        IRQ_CLR_OFS: stat_d = stat_q & ~wdata[EV_W-1:0];
        default: bresp_d = RESP_ERR;
      endcase
    end
    stat_d = stat_d | ev; // Set wins over clear
    if (rdGo)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OK;
      unique case (araddr)
        CTRL_OFS: rdata_d = {22'h0, ctrl_q};
        STATUS_OFS: rdata_d = {24'h00_0000, wakeDet_q, resetDet_q, rate_q, st_q, linkUp_q};
        TXWORD_OFS: rdata_d = {22'h0, txWord_q};
        RXWORD_OFS: rdata_d = {22'h0, rxWord_q};
        IRQ_STAT_OFS: rdata_d = {27'h0, stat_q};
        IRQ_EN_OFS: rdata_d = {27'h0, en_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_ERR;
        end
      endcase
    end
    irq_d = |(stat_d & en_d);
  end
  // Register bus flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      txWord_q <= TXWORD_RST;
      en_q <= IRQ_EN_RST;
      stat_q <= 5'h0_0;
      awready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
      rresp_q <= RESP_OK;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      txWord_q <= txWord_d;
      en_q <= en_d;
      stat_q <= stat_d;
      awready_q <= awready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end
  assign awready = awready_q;
  assign wready = awready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Line datapath and link control
  assign divTop = (rate_q == RATE_GEN1) ? GEN1_DIV : GEN2_DIV;
  assign bitEn = (div_q == divTop - 4'h1);
  assign rxEn = ctrl_q.nearLoopbackEn ? bitEn : (fltQ[1] && !lclk_q);
  assign rxBit = ctrl_q.nearLoopbackEn ? txSer_q : fltQ[0];
  assign rxSh_d = rxEn ? {rxBit, rxSh_q[9:1]} : rxSh_q;
  assign seen_a = rxEn && (rxSh_d == K285_NEG || rxSh_d == K285_POS);
  // Symbol choice for the next transmit slot
  always_comb
  begin
    nextSym = D102;
    if (st_q == ST_READY && !ctrl_q.bist)
      nextSym = txWord_q;
    else if (st_q == ST_WAIT && !ctrl_q.bist)
    begin
      unique case (alIdx_q)
        2'h0: nextSym = K285_NEG;
        2'h3: nextSym = D273;
        default: nextSym = D102;
      endcase
    end
  end
  // Link next-state logic
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q + 16'h1;
    rate_d = rate_q;
    alCnt_d = alCnt_q;
    div_d = bitEn ? 4'h0 : div_q + 4'h1;
    txCnt_d = txCnt_q;
    txSh_d = txSh_q;
    alIdx_d = alIdx_q;
    rxCnt_d = rxCnt_q;
    rxWord_d = rxWord_q;
    rxValid_d = 1'b0;
    if (bitEn)
    begin
      if (txCnt_q == SYM_LAST)
      begin
        txCnt_d = 4'h0;
        txSh_d = nextSym;
        alIdx_d = alIdx_q + 2'h1;
      end
      else
      begin
        txCnt_d = txCnt_q + 4'h1;
        txSh_d = {1'b0, txSh_q[9:1]};
      end
    end
    if (rxEn)
    begin
      rxCnt_d = rxCnt_q + 4'h1;
      if (seen_a || rxCnt_q == SYM_LAST)
      begin
        rxCnt_d = 4'h0;
        rxWord_d = rxSh_d;
        rxValid_d = 1'b1;
      end
    end
    if (seen_a && st_q == ST_WAIT && alCnt_q != ALIGN_NEED)
      alCnt_d = alCnt_q + 2'h1;
    unique case (st_q)
      ST_RESET:
        if (tmr_q == 16'(OOB_RESET_CYC))
        begin
          st_d = ST_WAIT;
          tmr_d = 16'h0;
          alCnt_d = 2'h0;
        end
      ST_WAIT:
        if (alCnt_q == ALIGN_NEED)
          st_d = ST_READY;
        else if (tmr_q == 16'(ALIGN_WAIT_CYC))
        begin
          st_d = ST_RESET;
          tmr_d = 16'h0;
          if (ctrl_q.rateSelect == RATE_AUTO)
            rate_d = (rate_q == RATE_GEN2) ? RATE_GEN1 : RATE_GEN2;
        end
      ST_READY:
        if (ctrl_q.slumberReq)
          st_d = ST_SLUMBER;
        else if (ctrl_q.partialReq)
          st_d = ST_PARTIAL;
      ST_SLUMBER:
        if (!ctrl_q.slumberReq || fltQ[4])
        begin
          st_d = ST_WAIT;
          tmr_d = 16'h0;
          alCnt_d = 2'h0;
        end
      ST_PARTIAL:
        if (!ctrl_q.partialReq || fltQ[4])
        begin
          st_d = ST_WAIT;
          tmr_d = 16'h0;
          alCnt_d = 2'h0;
        end
    endcase
    if (ctrl_q.rateSelect == RATE_GEN1 || ctrl_q.rateSelect == RATE_GEN2)
      rate_d = ctrl_q.rateSelect;
    if (ctrl_q.phyResetReq)
    begin
      st_d = ST_RESET;
      tmr_d = 16'h0;
    end
    linkUp_d = (st_d == ST_READY);
    txOob_d = (st_d == ST_RESET);
    txSer_d = ctrl_q.farLoopbackEn ? fltQ[0] : txSh_d[0];
    if (st_d == ST_SLUMBER || st_d == ST_PARTIAL || st_d == ST_RESET)
      txSer_d = 1'b0;
    seenA_d = seen_a;
    resetDet_d = ctrl_q.isHost ? fltQ[3] : fltQ[2];
    wakeDet_d = fltQ[4];
  end
  // Link flops
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_RESET;
      tmr_q <= 16'h0000;
      rate_q <= RATE_GEN2;
      alCnt_q <= 2'h0;
      alIdx_q <= 2'h0;
      div_q <= 4'h0;
      txCnt_q <= 4'h0;
      rxCnt_q <= 4'h0;
      txSh_q <= 10'h000;
      rxSh_q <= 10'h000;
      rxWord_q <= 10'h000;
      rxValid_q <= 1'b0;
      txSer_q <= 1'b0;
      txOob_q <= 1'b0;
      linkUp_q <= 1'b0;
      seenA_q <= 1'b0;
      resetDet_q <= 1'b0;
      wakeDet_q <= 1'b0;
      lclk_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      rate_q <= rate_d;
      alCnt_q <= alCnt_d;
      alIdx_q <= alIdx_d;
      div_q <= div_d;
      txCnt_q <= txCnt_d;
      rxCnt_q <= rxCnt_d;
      txSh_q <= txSh_d;
      rxSh_q <= rxSh_d;
      rxWord_q <= rxWord_d;
      rxValid_q <= rxValid_d;
      txSer_q <= txSer_d;
      txOob_q <= txOob_d;
      linkUp_q <= linkUp_d;
      seenA_q <= seenA_d;
      resetDet_q <= resetDet_d;
      wakeDet_q <= wakeDet_d;
      lclk_q <= fltQ[1];
    end
  end
  assign txSer = txSer_q;
  assign txOob = txOob_q;
  assign linkUp = linkUp_q;
  assign seenA = seenA_q;
  assign resetDet = resetDet_q;
  assign wakeDet = wakeDet_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_reset_drops_link: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_q.phyResetReq |=> !linkUp && txOob) else $error("link up during reset request");
  a_oob_while_reset: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(ctrl_q.phyResetReq) |=> st_q == ST_RESET) else $error("reset state not entered");
  a_linkup_ready: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(linkUp) |-> $past(alCnt_q) == ALIGN_NEED) else $error("link up without align");
  a_slumber_entry: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == ST_READY && ctrl_q.slumberReq && !ctrl_q.phyResetReq |=> st_q == ST_SLUMBER)
    else $error("slumber not entered");
  a_partial_entry: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == ST_READY && !ctrl_q.slumberReq && ctrl_q.partialReq && !ctrl_q.phyResetReq
    |=> st_q == ST_PARTIAL) else $error("partial not entered");
  a_seen_a_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    seen_a |=> seenA ##1 !seenA) else $error("seen_a pulse wrong");
  a_reset_detect: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_q.isHost && $stable(ctrl_q) |=> resetDet == $past(fltQ[3])) else $error("host detect wrong");
  a_dev_detect: assert property (@(posedge mclk) disable iff (!rstn)
    !ctrl_q.isHost && $stable(ctrl_q) |=> resetDet == $past(fltQ[2])) else $error("device detect wrong");
  a_wake_detect: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> wakeDet == $past(fltQ[4])) else $error("wake detect wrong");
  a_rate_forced: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_q.rateSelect == RATE_GEN1 ##1 ctrl_q.rateSelect == RATE_GEN1 |-> rate_q == RATE_GEN1)
    else $error("forced rate ignored");
  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    irq == |(stat_q & en_q)) else $error("interrupt mismatch");
endmodule
`default_nettype wire

// >>> shared/phy_ctrl_pkg.sv
// Package: register map, timing, line symbols and types of the PHY control block
`default_nettype none
package phy_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TXWORD_OFS = 8'h08;
  localparam logic [7:0] RXWORD_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  // Reset values
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [9:0] TXWORD_RST = 10'h2AA;
  localparam logic [4:0] IRQ_EN_RST = 5'h00;
  // Event bit positions
  localparam int EV_SEEN_A = 0;
  localparam int EV_RXWORD = 1;
  localparam int EV_LINKUP = 2;
  localparam int EV_RESETDET = 3;
  localparam int EV_WAKE = 4;
  localparam int EV_W = 5;
  // Rate codes
  localparam logic [1:0] RATE_AUTO = 2'h0;
  localparam logic [1:0] RATE_GEN1 = 2'h1;
  localparam logic [1:0] RATE_GEN2 = 2'h2;
  // Clock cycles per line bit at each rate
  localparam logic [3:0] GEN1_DIV = 4'h8;
  localparam logic [3:0] GEN2_DIV = 4'h4;
  // Line symbols, bit 0 sent first
  localparam logic [9:0] K285_NEG = 10'h17C;
  localparam logic [9:0] K285_POS = 10'h283;
  localparam logic [9:0] D102 = 10'h2AA;
  localparam logic [9:0] D273 = 10'h31B;
  localparam logic [3:0] SYM_LAST = 4'h9;
  localparam logic [1:0] ALIGN_NEED = 2'h2;
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int OOB_RESET_NS = 64000;
  localparam int ALIGN_WAIT_NS = 400000;
  localparam int OOB_RESET_CYC = OOB_RESET_NS * CLK_MHZ / 1000;
  localparam int ALIGN_WAIT_CYC = ALIGN_WAIT_NS * CLK_MHZ / 1000;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Link states
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_WAIT = 3'h1,
    ST_READY = 3'h2,
    ST_SLUMBER = 3'h3,
    ST_PARTIAL = 3'h4
  } link_state_e;
  // Control register layout
  typedef struct packed {
    logic [1:0] rateSelect;
    logic isHost;
    logic bist;
    logic farLoopbackEn;
    logic nearLoopbackEn;
    logic partialReq;
    logic slumberReq;
    logic phyResetReq;
    logic spare;
  } ctrl_s;
endpackage
`default_nettype wire

// >>> verif/far_end_model.sv
// Far-end serial transmitter model driving the receive line and its line clock
`timescale 1ns/1ps
`default_nettype none
module far_end_model
(
  input wire logic sendEn,
  input wire logic [39:0] pattern,
  output logic rxSer,
  output logic rxLineClk
);
  ////////////////////////////////////////////////////////////////
  // Whole symbol groups, bit 0 first; clock stands still when idle
  initial
  begin
    rxLineClk = 1'b0;
    rxSer = 1'b0;
    #137;
    forever
    begin
      if (sendEn)
      begin
        for (int i = 0; i < 40; i++)
        begin
          rxSer = pattern[i];
          #400 rxLineClk = 1'b1;
          #400 rxLineClk = 1'b0;
        end
      end
      else
      begin
        rxSer = ~rxSer; // Idle line never holds a stale level
        #400;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench: register bus, serial link and control scenarios
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top
  import phy_ctrl_pkg::*;
;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic rxSer, rxLineClk, comresetSense, cominitSense, comwakeSense, sendEn;
  logic txSer, txOob, linkUp, seenA, resetDet, wakeDet, irq;
  int err_count, samples_checked, cycles, commas, n;

  ////////////////////////////////////////////////////////////////
  // Clock, design and far end
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  phy_ctrl u_dut (.mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rxSer(rxSer), .rxLineClk(rxLineClk), .comresetSense(comresetSense),
    .cominitSense(cominitSense), .comwakeSense(comwakeSense), .txSer(txSer), .txOob(txOob),
    .linkUp(linkUp), .seenA(seenA), .resetDet(resetDet), .wakeDet(wakeDet), .irq(irq));
  far_end_model u_far (.sendEn(sendEn), .pattern({D273, D102, D102, K285_NEG}), .rxSer(rxSer),
    .rxLineClk(rxLineClk));

  // Watchdog and seen_a pulse counter
  always @(posedge mclk)
  begin
    cycles++;
    if (seenA === 1'b1) commas++;
    if (cycles == 20000)
    begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge mclk);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Link and line helpers
  task automatic wait_oob();
    int k;
    k = 0;
    while (txOob === 1'b1 && k < 2000)
    begin
      @(posedge mclk);
      k++;
    end
    `CHK(k >= OOB_RESET_CYC - 20 && k <= OOB_RESET_CYC + 2, 1'b1)
    `CHK(linkUp, 1'b0)
  endtask

  task automatic wait_link();
    int k;
    k = 0;
    sendEn <= 1'b1;
    while (linkUp !== 1'b1 && k < 4000)
    begin
      @(posedge mclk);
      k++;
    end
    `CHK(linkUp, 1'b1)
    sendEn <= 1'b0;
    repeat (400) @(posedge mclk);
  endtask

  task automatic count_tog(output int t);
    logic p;
    repeat (100) @(posedge mclk);
    t = 0;
    p = txSer;
    repeat (80)
    begin
      @(posedge mclk);
      if (txSer !== p) t++;
      p = txSer;
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, sendEn} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {comresetSense, cominitSense, comwakeSense} = 3'h0;
    {err_count, samples_checked, cycles, commas} = 128'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(txOob, 1'b1)
    wait_oob();
    rd(CTRL_OFS, d, r);
    `CHK(d[9:0], CTRL_RST)
    rd(TXWORD_OFS, d, r);
    `CHK(d[9:0], TXWORD_RST)
    rd(IRQ_EN_OFS, d, r);
    `CHK(d[4:0], IRQ_EN_RST)
    rd(8'h1c, d, r);
    `CHK({r, d}, {RESP_ERR, 32'h0000_0000})
    wr(8'h20, 32'hffff_ffff, r);
    `CHK(r, RESP_ERR)
    end_test("reset");
    wait_link();
    `CHK(commas >= 2, 1'b1)
    rd(STATUS_OFS, d, r);
    `CHK(d[3:0], {ST_READY, 1'b1})
    rd(RXWORD_OFS, d, r);
    `CHK(d[9:0], D273)
    rd(IRQ_STAT_OFS, d, r);
    `CHK(d[EV_SEEN_A], 1'b1)
    wr(IRQ_EN_OFS, 32'h0000_0001, r);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    wr(IRQ_EN_OFS, 32'h0000_0000, r);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(IRQ_EN_OFS, 32'h0000_0001, r);
    wr(IRQ_CLR_OFS, 32'h0000_001f, r);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    rd(IRQ_STAT_OFS, d, r);
    `CHK(d[4:0], 5'h00)
    end_test("link");
    wr(TXWORD_OFS, 32'h0000_0000, r);
    count_tog(n);
    `CHK(n == 0, 1'b1)
    wr(TXWORD_OFS, {22'h0, K285_NEG}, r);
    wr(CTRL_OFS, 32'h0000_0010, r);
    n = commas;
    repeat (200) @(posedge mclk);
    `CHK(commas - n >= 2, 1'b1)
    rd(RXWORD_OFS, d, r);
    `CHK(d[9:0], K285_NEG)
    wr(CTRL_OFS, 32'h0000_0040, r);
    count_tog(n);
    `CHK(n >= 8, 1'b1)
    wr(CTRL_OFS, 32'h0000_0020, r);
    count_tog(n);
    `CHK(n >= 16 && n <= 24, 1'b1)
    for (int i = 1; i < 3; i++)
    begin
      wr(CTRL_OFS, 32'(i) << 8, r);
      repeat (4) @(posedge mclk);
      rd(STATUS_OFS, d, r);
      `CHK(d[5:4], 2'(i))
    end
    end_test("transmit");
    wr(CTRL_OFS, 32'h0000_0002, r);
    repeat (2) @(posedge mclk);
    `CHK({txOob, linkUp}, 2'b10)
    wr(CTRL_OFS, 32'h0000_0000, r);
    wait_oob();
    wait_link();
    for (int i = 0; i < 2; i++)
    begin
      wr(CTRL_OFS, 32'h0000_0004 << i, r);
      repeat (4) @(posedge mclk);
      rd(STATUS_OFS, d, r);
      `CHK(d[3:1], (i == 1) ? ST_PARTIAL : ST_SLUMBER)
      `CHK(txSer, 1'b0)
      wr(CTRL_OFS, 32'h0000_0000, r);
      wait_link();
    end
    end_test("power");
    wr(CTRL_OFS, 32'h0000_0080, r);
    cominitSense <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK(resetDet, 1'b1)
    cominitSense <= 1'b0;
    comresetSense <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK(resetDet, 1'b0)
    wr(CTRL_OFS, 32'h0000_0000, r);
    repeat (8) @(posedge mclk);
    `CHK(resetDet, 1'b1)
    comresetSense <= 1'b0;
    comwakeSense <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK({wakeDet, resetDet}, 2'b10)
    end_test("oob");
    stop_test();
  end
endmodule
`default_nettype wire
